/* File: prmb_builder.sv */
// once per second performance report frame builder with lsb first bit output
//
// Notes on behaviour
// - each octet leaves least significant bit first, most significant bit last.
// - customer side address octet 00111000, then 00000001, then control 00000011.
// - carrier side address octet is 00111010, command/response bit set.
// - latest completed second's status word goes in octets 5 and 6.
// - three older words follow in octets 7-8, 9-10, 11-12, shifting each second.
// - crc16 check sequence in octets 13 and 14, then closing flag 01111110.
// - exactly one crc range indicator set per nonzero error count in a second.
// - severe framing indicator set on any event; it forces framing bit error clear.
// - framing bit error indicator set on any such error, only without severe framing.
// - line violation, slip and payload loopback indicators follow their events.
// - both study bits and the reserved bit are always zero.
// - two bit report counter advances each report, wrapping modulo four.
`timescale 1ns/1ps
module prmb_builder
   import prmb_pkg::*;
(
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // one second boundary and origin select
   input wire logic second_tick_in,
   input wire logic from_carrier_in,
   // per second events
   input wire logic crc_err_in,
   input wire logic severe_frm_in,
   input wire logic frm_bit_err_in,
   input wire logic line_viol_in,
   input wire logic slip_in,
   input wire logic payload_loop_in,
   // serial output towards the hdlc transmitter
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output logic tx_bit_out,
   output logic tx_frame_start_out,
   // status
   output logic busy_out,
   output logic [1:0] report_seq_counter_out
);
   import prmb_pkg::*;

   typedef enum logic [1:0] {PRMB_IDLE, PRMB_BUILD} prmb_state_t;

   prmb_state_t state;
   logic [8:0] crc_cnt;
   logic severe_seen;
   logic frm_err_seen;
   logic viol_seen;
   logic slip_seen;
   logic loop_seen;
   logic [1:0] report_seq_counter;
   logic [15:0] hist [HIST_WORDS];
   logic [15:0] frame_words [HIST_WORDS];
   logic frame_carrier;
   logic pending;
   logic [3:0] octet_idx;
   logic [15:0] fcs;
   logic [7:0] shift;
   logic [2:0] bit_idx;
   logic shift_full;
   logic tx_bit;
   logic frame_start;

   // fifo ports
   logic wr_ready;
   logic rd_valid;
   logic [7:0] rd_data;

   // running crc count, held at the top bound so 320+ stays stable
   wire [8:0] crc_cnt_now = (crc_cnt >= CRC_SAT) ? crc_cnt : crc_cnt + 9'(crc_err_in);

   // the tick cycle's own events still belong to the closing second
   wire crc_err_eq1 = (crc_cnt_now == 9'h001);
   wire crc_err_2_to_5 = (crc_cnt_now >= CRC_R2_LO) && (crc_cnt_now <= CRC_R2_HI);
   wire crc_err_6_to_10 = (crc_cnt_now > CRC_R2_HI) && (crc_cnt_now <= CRC_R3_HI);
   wire crc_err_11_to_100 = (crc_cnt_now > CRC_R3_HI) && (crc_cnt_now <= CRC_R4_HI);
   wire crc_err_101_to_319 = (crc_cnt_now > CRC_R4_HI) && (crc_cnt_now <= CRC_R5_HI);
   wire crc_err_320_plus = (crc_cnt_now >= CRC_SAT);
   wire severe_framing_flag = severe_seen || severe_frm_in;
   wire framing_bit_err_flag = (frm_err_seen || frm_bit_err_in) && !severe_framing_flag;
   wire line_violation_flag = viol_seen || line_viol_in;
   wire slip_flag = slip_seen || slip_in;
   wire payload_loop_flag = loop_seen || payload_loop_in;
   wire sync_study_bit_a = 1'b0;
   wire sync_study_bit_b = 1'b0;
   wire reserved_bit = 1'b0;

   wire [7:0] word_hi = {crc_err_6_to_10, line_violation_flag, crc_err_11_to_100,
      sync_study_bit_a, sync_study_bit_b, crc_err_101_to_319, slip_flag, crc_err_320_plus};
   wire [7:0] word_lo = {framing_bit_err_flag, severe_framing_flag, payload_loop_flag,
      crc_err_eq1, reserved_bit, crc_err_2_to_5, report_seq_counter};
   wire [15:0] new_word = {word_hi, word_lo};

   wire tick = second_tick_in && clk_en_in;
   wire start = (state == PRMB_IDLE) && pending;

   // octet selection by frame position
   wire [2:0] data_word = 3'((octet_idx - IDX_DATA_FIRST) >> 1);
   wire [15:0] data_sel = frame_words[data_word[1:0]];
   wire is_data = (octet_idx >= IDX_DATA_FIRST) && (octet_idx <= IDX_DATA_LAST);
   wire [7:0] data_octet = octet_idx[0] ? data_sel[7:0] : data_sel[15:8];
   wire [15:0] fcs_out = ~fcs;
   wire [7:0] addr_octet = frame_carrier ? ADDR_CARRIER_OCTET : ADDR_CI_OCTET;
   wire [7:0] octet =
      (octet_idx == IDX_OPEN_FLAG) ? FLAG_OCTET :
      (octet_idx == IDX_ADDR) ? addr_octet :
      (octet_idx == IDX_ENDPOINT) ? ENDPOINT_OCTET :
      (octet_idx == IDX_CTRL) ? CTRL_OCTET :
      is_data ? data_octet :
      (octet_idx == IDX_FCS_LO) ? fcs_out[7:0] :
      (octet_idx == IDX_FCS_HI) ? fcs_out[15:8] :
      FLAG_OCTET;
   wire wr_valid = (state == PRMB_BUILD);
   wire push = wr_valid && wr_ready && clk_en_in;
   wire in_fcs_span = (octet_idx >= IDX_ADDR) && (octet_idx <= IDX_DATA_LAST);

   // reflected crc16 over one octet, lsb first like the wire order
   function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ FCS_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // per second event accumulation
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         crc_cnt <= CRC_CNT_RESET;
         severe_seen <= 1'b0;
         frm_err_seen <= 1'b0;
         viol_seen <= 1'b0;
         slip_seen <= 1'b0;
         loop_seen <= 1'b0;
      end
      else if (clk_en_in)
      begin
         crc_cnt <= second_tick_in ? CRC_CNT_RESET : crc_cnt_now;
         severe_seen <= !second_tick_in && severe_framing_flag;
         frm_err_seen <= !second_tick_in && (frm_err_seen || frm_bit_err_in);
         viol_seen <= !second_tick_in && line_violation_flag;
         slip_seen <= !second_tick_in && slip_flag;
         loop_seen <= !second_tick_in && payload_loop_flag;
      end
   end

   // history shift and report counter at each second boundary
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         report_seq_counter <= SEQ_RESET;
         for (int i = 0; i < HIST_WORDS; i++)
         begin
            hist[i] <= WORD_RESET;
         end
      end
      else if (tick)
      begin
         report_seq_counter <= report_seq_counter + 2'h1;
         hist[0] <= new_word;
         for (int i = 1; i < HIST_WORDS; i++)
         begin
            hist[i] <= hist[i-1];
         end
      end
   end

   // frame build: snapshot the history so a later tick cannot tear the frame
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state <= PRMB_IDLE;
         pending <= 1'b0;
         octet_idx <= IDX_OPEN_FLAG;
         fcs <= FCS_INIT;
         frame_carrier <= 1'b0;
         for (int i = 0; i < HIST_WORDS; i++)
         begin
            frame_words[i] <= WORD_RESET;
         end
      end
      else if (clk_en_in)
      begin
         case (state)
            PRMB_IDLE:
            begin
               pending <= 1'b0;
               if (start)
               begin
                  state <= PRMB_BUILD;
                  octet_idx <= IDX_OPEN_FLAG;
                  fcs <= FCS_INIT;
                  frame_carrier <= from_carrier_in;
                  frame_words <= hist;
               end
            end
            PRMB_BUILD:
            begin
               if (second_tick_in)
               begin
                  pending <= 1'b1;
               end
               if (push)
               begin
                  if (in_fcs_span)
                  begin
                     fcs <= fcs_step(fcs, octet);
                  end
                  if (octet_idx == IDX_CLOSE_FLAG)
                  begin
                     state <= PRMB_IDLE;
                  end
                  octet_idx <= octet_idx + 4'h1;
               end
            end
            default:
            begin
               state <= PRMB_IDLE;
            end
         endcase
         if (state == PRMB_IDLE && second_tick_in)
         begin
            pending <= 1'b1;
         end
      end
   end

   prmb_fifo #(
      .WIDTH(OCTET_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .wr_valid_in(wr_valid),
      .wr_ready_out(wr_ready),
      .wr_data_in(octet),
      .rd_valid_out(rd_valid),
      .rd_ready_in(!shift_full),
      .rd_data_out(rd_data)
   );

   // serialiser: the output bit is the flopped lsb of the shifter
   wire load = rd_valid && !shift_full && clk_en_in;
   wire bit_done = shift_full && tx_ready_in && clk_en_in;

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         shift <= 8'h00;
         bit_idx <= 3'h0;
         shift_full <= 1'b0;
         tx_bit <= 1'b0;
         frame_start <= 1'b0;
      end
      else
      begin
         if (load)
         begin
            shift <= rd_data >> 1;
            tx_bit <= rd_data[0];
            bit_idx <= 3'h0;
            shift_full <= 1'b1;
         end
         else if (bit_done)
         begin
            shift <= shift >> 1;
            tx_bit <= shift[0];
            bit_idx <= bit_idx + 3'h1;
            shift_full <= (bit_idx != BIT_IDX_LAST);
         end
         if (push)
         begin
            frame_start <= (octet_idx == IDX_OPEN_FLAG);
         end
      end
   end

   assign tx_valid_out = shift_full;
   assign tx_bit_out = tx_bit;
   assign tx_frame_start_out = frame_start;
   assign busy_out = (state == PRMB_BUILD) || rd_valid || shift_full;
   assign report_seq_counter_out = report_seq_counter;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   chk_open_flag: assert property (push && octet_idx == IDX_OPEN_FLAG |->
      octet == 8'h7e)
      else $error("opening flag octet wrong");
   chk_addr_octet: assert property (push && octet_idx == IDX_ADDR |->
      octet == (frame_carrier ? 8'h3a : 8'h38))
      else $error("address octet wrong");
   chk_fixed_octets: assert property (push && (octet_idx == IDX_ENDPOINT || octet_idx == IDX_CTRL) |->
      octet == ((octet_idx == IDX_CTRL) ? 8'h03 : 8'h01))
      else $error("endpoint or control octet wrong");
   chk_close_flag: assert property (push && octet_idx == IDX_CLOSE_FLAG |->
      octet == 8'h7e ##1 state == PRMB_IDLE)
      else $error("closing flag or end of frame wrong");
   chk_crc_range: assert property (tick |->
      $onehot({word_hi[7], word_hi[5], word_hi[2], word_hi[0], word_lo[4], word_lo[2]})
      == (crc_cnt_now != 9'h000))
      else $error("crc range indicators not one hot");
   chk_severe_excl: assert property (tick |-> !(word_lo[7] && word_lo[6])
      && (word_lo[6] == (severe_seen || severe_frm_in)))
      else $error("severe framing and framing bit error both set");
   chk_spare_zero: assert property (tick |=>
      hist[0][12:11] == 2'b00 && hist[0][3] == 1'b0)
      else $error("study or reserved bit not zero");
   chk_seq_wrap: assert property (tick |=>
      report_seq_counter == 2'($past(report_seq_counter) + 1)
      && hist[0][1:0] == $past(report_seq_counter))
      else $error("report counter did not advance");
   chk_hist_shift: assert property (tick |=> hist[1] == $past(hist[0])
      && hist[3] == $past(hist[2]))
      else $error("history did not shift");
   chk_lsb_first: assert property (load |=>
      tx_bit_out == $past(rd_data[0]) && tx_valid_out)
      else $error("octet not sent lsb first");
   chk_slip_flag: assert property (tick && slip_in |=> hist[0][9])
      else $error("slip indicator missing");
endmodule

/* File: prmb_builder_tb_top.sv */
// self-checking bench for the report frame builder
`timescale 1ns/1ps
module prmb_builder_tb_top;
   import prmb_pkg::*;
   logic clock_in, arst_n_in, clk_en_in, second_tick_in, from_carrier_in;
   logic crc_err_in, severe_frm_in, frm_bit_err_in, line_viol_in, slip_in, payload_loop_in;
   logic tx_valid_out, tx_ready_in, tx_bit_out, busy_out, slow;
   logic tx_frame_start_out, fs_prev;
   logic [1:0] report_seq_counter_out;
   logic [15:0] hist [4];
   logic [1:0] cnt;
   logic exp_q [$];
   int n_mismatch, n_tests, n_frames, n_starts;
   int crc_tab [12] = '{0, 1, 2, 5, 6, 10, 11, 100, 101, 319, 320, 400};

   prmb_builder uut (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .second_tick_in(second_tick_in),
      .from_carrier_in(from_carrier_in),
      .crc_err_in(crc_err_in),
      .severe_frm_in(severe_frm_in),
      .frm_bit_err_in(frm_bit_err_in),
      .line_viol_in(line_viol_in),
      .slip_in(slip_in),
      .payload_loop_in(payload_loop_in),
      .tx_valid_out(tx_valid_out),
      .tx_ready_in(tx_ready_in),
      .tx_bit_out(tx_bit_out),
      .tx_frame_start_out(tx_frame_start_out),
      .busy_out(busy_out),
      .report_seq_counter_out(report_seq_counter_out)
   );

   prmb_sink u_sink (
      .clock_in(clock_in),
      .slow_in(slow),
      .ready_out(tx_ready_in)
   );

   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   task automatic fail(input string msg);
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
   endtask

   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) fail("serial bit differs");
   endtask

   task automatic check_cnt(input logic [1:0] exp);
      n_tests++;
      if (report_seq_counter_out !== exp) fail("report counter differs");
   endtask

   task automatic check_starts;
      n_tests++;
      if (n_starts != n_frames) fail("frame start count differs");
   endtask

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // octets leave bit 0 first, so the queue holds bits in wire order
   task automatic expect_frame;
      logic [7:0] oc [15];
      logic [15:0] fcs;
      oc[0] = 8'h7e;
      oc[1] = from_carrier_in ? 8'h3a : 8'h38;
      oc[2] = 8'h01;
      oc[3] = 8'h03;
      for (int w = 0; w < 4; w++)
      begin
         oc[4 + 2 * w] = hist[w][15:8];
         oc[5 + 2 * w] = hist[w][7:0];
      end
      fcs = 16'hffff;
      for (int k = 1; k < 12; k++)
         for (int b = 0; b < 8; b++)
            fcs = ((fcs[0] ^ oc[k][b]) == 1'b1) ? ((fcs >> 1) ^ 16'h8408) : (fcs >> 1);
      fcs = ~fcs;
      oc[12] = fcs[7:0];
      oc[13] = fcs[15:8];
      oc[14] = 8'h7e;
      n_frames++;
      foreach (oc[k])
         for (int i = 0; i < 8; i++)
            exp_q.push_back(oc[k][i]);
   endtask

   // one second of events, closed by a tick; ev = loop, slip, violation, bit error, severe
   task automatic run_second(input int n, input logic [4:0] ev, input logic carrier);
      logic [7:0] hi, lo;
      logic frm_err;
      frm_err = ev[1] & ~ev[0];
      hi = {n > 5 && n <= 10, ev[2], n > 10 && n <= 100, 2'b00,
         n > 100 && n <= 319, ev[3], n >= 320};
      lo = {frm_err, ev[0], ev[4], n == 1, 1'b0, n >= 2 && n <= 5, cnt};
      for (int i = 0; i < ((n > 0) ? n : 1); i++)
      begin
         @(negedge clock_in);
         from_carrier_in = carrier;
         crc_err_in = i < n;
         severe_frm_in = ev[0] && i == 0;
         frm_bit_err_in = ev[1] && i == 0;
         line_viol_in = ev[2] && i == 0;
         slip_in = ev[3] && i == 0;
         payload_loop_in = ev[4] && i == 0;
      end
      @(negedge clock_in);
      {crc_err_in, severe_frm_in, frm_bit_err_in, line_viol_in, payload_loop_in} = '0;
      // a slip in the tick cycle still belongs to the closing second
      slip_in = ev[3];
      second_tick_in = 1'b1;
      for (int w = 3; w > 0; w--)
         hist[w] = hist[w - 1];
      hist[0] = {hi, lo};
      expect_frame();
      cnt++;
      @(negedge clock_in);
      second_tick_in = 1'b0;
      slip_in = 1'b0;
      check_cnt(cnt);
   endtask

   task automatic wait_idle;
      int t;
      t = 0;
      // draining with a random clock enable checks that a low enable freezes the shifter
      while ((busy_out !== 1'b0 || exp_q.size() != 0) && t < 4000)
      begin
         clk_en_in = 1'($urandom_range(3) != 0);
         @(negedge clock_in);
         t++;
      end
      clk_en_in = 1'b1;
      if (t >= 4000) fail("frame never drained");
   endtask

   task automatic do_reset;
      @(negedge clock_in);
      arst_n_in = 1'b0;
      repeat (3) @(negedge clock_in);
      arst_n_in = 1'b1;
      cnt = 2'b00;
      foreach (hist[w])
         hist[w] = 16'h0000;
      check_cnt(2'b00);
   endtask

   // takes happen at the rising edge, so pre-edge values are the ones taken
   always @(posedge clock_in)
   begin
      if (tx_frame_start_out === 1'b1 && fs_prev !== 1'b1)
         n_starts++;
      fs_prev = tx_frame_start_out;
      if (arst_n_in === 1'b1 && clk_en_in === 1'b1 && tx_valid_out === 1'b1
         && tx_ready_in === 1'b1)
      begin
         if (exp_q.size() == 0)
            fail("unexpected serial bit");
         else
            check_bit(tx_bit_out, exp_q.pop_front());
      end
   end

   initial
   begin
      {arst_n_in, second_tick_in, from_carrier_in, slow} = '0;
      {crc_err_in, severe_frm_in, frm_bit_err_in, line_viol_in, slip_in, payload_loop_in} = '0;
      clk_en_in = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      n_frames = 0;
      n_starts = 0;
      void'($urandom(11535));
      do_reset();
      foreach (crc_tab[k])
      begin
         slow = 1'($urandom_range(1));
         run_second(crc_tab[k], 5'($urandom), 1'($urandom));
         wait_idle();
      end
      // three reports close together behind a stalling sink fill the fifo
      slow = 1'b1;
      repeat (3)
      begin
         run_second(0, 5'h00, 1'b1);
         repeat (20) @(negedge clock_in);
      end
      wait_idle();
      // reset in mid-run clears history; every event at once
      do_reset();
      slow = 1'b0;
      run_second(1, 5'h1f, 1'b0);
      wait_idle();
      check_starts();
      summarize();
   end

   initial
   begin
      #200000;
      fail("watchdog expired");
      summarize();
   end
endmodule

/* File: prmb_fifo.sv */
// octet fifo between the frame builder and the bit serialiser
`timescale 1ns/1ps
module prmb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // write side
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   // read side
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire do_wr = wr_valid_in && wr_ready_out && clk_en_in;
   wire do_rd = rd_valid_out && rd_ready_in && clk_en_in;

   assign wr_ready_out = (count != (AW+1)'(DEPTH));
   assign rd_valid_out = (count != '0);
   assign rd_data_out = mem[rd_ptr];

   always_ff @(posedge clock_in)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= wr_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd)
         begin
            count <= count + 1'b1;
         end
         else if (do_rd && !do_wr)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* File: prmb_pkg.sv */
// constants and octet layout for the performance report message builder
package prmb_pkg;
   // octet stream and fifo geometry
   localparam int OCTET_W = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int FRAME_OCTETS = 15;
   localparam int HIST_WORDS = 4;

   // fixed octets of the frame
   localparam logic [7:0] FLAG_OCTET = 8'h7e;
   localparam logic [7:0] ADDR_CI_OCTET = 8'h38;
   localparam logic [7:0] ADDR_CARRIER_OCTET = 8'h3a;
   localparam logic [7:0] ENDPOINT_OCTET = 8'h01;
   localparam logic [7:0] CTRL_OCTET = 8'h03;

   // zero based octet positions within the frame
   localparam logic [3:0] IDX_OPEN_FLAG = 4'h0;
   localparam logic [3:0] IDX_ADDR = 4'h1;
   localparam logic [3:0] IDX_ENDPOINT = 4'h2;
   localparam logic [3:0] IDX_CTRL = 4'h3;
   localparam logic [3:0] IDX_DATA_FIRST = 4'h4;
   localparam logic [3:0] IDX_DATA_LAST = 4'hb;
   localparam logic [3:0] IDX_FCS_LO = 4'hc;
   localparam logic [3:0] IDX_FCS_HI = 4'hd;
   localparam logic [3:0] IDX_CLOSE_FLAG = 4'he;

   // crc error count ranges, count saturates at the top bound
   localparam logic [8:0] CRC_CNT_RESET = 9'h000;
   localparam logic [8:0] CRC_R2_LO = 9'h002;
   localparam logic [8:0] CRC_R2_HI = 9'h005;
   localparam logic [8:0] CRC_R3_HI = 9'h00a;
   localparam logic [8:0] CRC_R4_HI = 9'h064;
   localparam logic [8:0] CRC_R5_HI = 9'h13f;
   localparam logic [8:0] CRC_SAT = 9'h140;

   // frame check sequence, reflected crc16
   localparam logic [15:0] FCS_INIT = 16'hffff;
   localparam logic [15:0] FCS_POLY = 16'h8408;

   // reset values and last serial bit index
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] SEQ_RESET = 2'h0;
   localparam logic [2:0] BIT_IDX_LAST = 3'h7;
endpackage

/* File: prmb_sink.sv */
// behavioural hdlc transmitter that takes the serial report bits
`timescale 1ns/1ps
module prmb_sink
(
   // clock
   input wire logic clock_in,
   // pacing and handshake
   input wire logic slow_in,
   output logic ready_out
);
   // slow mode takes about one bit in four so the fifo backs up behind it
   initial
   begin
      ready_out = 1'b0;
      forever
      begin
         @(negedge clock_in);
         ready_out <= slow_in ? ($urandom_range(3) == 0) : 1'b1;
      end
   end
endmodule
